// *** hw/brs_pkg.sv ***
// shared constants and types for the regulator sequencer
package brs_pkg;
   // clock and timing
   localparam int CLK_MHZ        = 200;
   localparam int BIAS_NS        = 2000;
   localparam int BIAS_CYC       = (BIAS_NS * CLK_MHZ) / 1000;
   localparam int BLANK_NS       = 360;
   localparam int BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SLEW_BASE_NS   = 1000;
   localparam int SLEW_BASE_CYC  = (SLEW_BASE_NS * CLK_MHZ) / 1000;
   localparam int PG_DELAY_MS    = 45;
   localparam int PG_DELAY_CYC   = PG_DELAY_MS * CLK_MHZ * 1000;
   localparam int HICCUP_US      = 1200;
   localparam int HICCUP_CYC     = HICCUP_US * CLK_MHZ;
   localparam int TIMER_W        = 24;
   localparam int BLANK_W        = 7;
   localparam int SLEW_CNT_W     = 11;
   // levels in units of 0.1 mV
   localparam int LVL_W          = 14;
   localparam int CODE_W         = 7;
   localparam logic [13:0] REF_BASE = 14'h1770;
   localparam logic [13:0] REF_STEP = 14'h002f;
   // thresholds in tenths of the reference
   localparam logic [17:0] TENTHS     = 18'h0000a;
   localparam logic [17:0] TRIP_TEN   = 18'h00008;
   localparam logic [17:0] OK_LO_TEN  = 18'h00009;
   localparam logic [17:0] OK_HI_TEN  = 18'h0000b;
   // register byte offsets
   localparam int ADDR_W         = 8;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_REF      = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
   // control fields
   localparam int CTRL_EN        = 0;
   localparam int CTRL_PSM       = 1;
   localparam int CTRL_OVP       = 2;
   localparam int CTRL_UVONLY    = 3;
   localparam int CTRL_SLEW      = 4;
   localparam logic [5:0] CTRL_RST = 6'h03;
   localparam logic [6:0] REF_CODE_RST = 7'h40;
   // status fields
   localparam int STAT_ST        = 16;
   localparam int STAT_OK        = 20;
   // event bits
   localparam int EV_W           = 5;
   localparam int EV_OCP         = 0;
   localparam int EV_HICCUP      = 1;
   localparam int EV_OK_RISE     = 2;
   localparam int EV_OK_FALL     = 3;
   localparam int EV_OVP         = 4;
   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_BIAS   = 3'b001,
      ST_RAMP   = 3'b011,
      ST_RUN    = 3'b010,
      ST_HICCUP = 3'b110
   } brs_state_t;
endpackage

// *** hw/brs_sync.sv ***
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module brs_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } brs_sync_t;

   brs_sync_t r;
   brs_sync_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.s2;
endmodule

// *** hw/brs_ref_slew.sv ***
// reference level stepper with selectable slew
`timescale 1ns/10ps
module brs_ref_slew (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // control
   input  wire logic        restart,
   input  wire logic [1:0]  slew_sel,
   input  wire logic [13:0] target,
   // level
   output logic      [13:0] ref_now,
   output logic             at_target
);
   typedef struct packed {
      logic [10:0] cnt;
      logic [13:0] lvl;
   } brs_slew_t;

   brs_slew_t   r;
   brs_slew_t   next_r;
   logic [10:0] period;
   logic        step;

   always_comb begin
      next_r = r;
      period = 11'(brs_pkg::SLEW_BASE_CYC) << slew_sel;
      step   = (r.cnt == period - 11'h001);
      if (restart) begin
         next_r.cnt = '0;
         next_r.lvl = '0;
      end else begin
         next_r.cnt = step ? '0 : r.cnt + 11'h001;
         if (step && r.lvl < target) begin
            next_r.lvl = (target - r.lvl > brs_pkg::REF_STEP) ?
                         r.lvl + brs_pkg::REF_STEP : target;
         end else if (step && r.lvl > target) begin
            next_r.lvl = (r.lvl - target > brs_pkg::REF_STEP) ?
                         r.lvl - brs_pkg::REF_STEP : target;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ref_now   = r.lvl;
   assign at_target = (r.lvl == target);

   a_slew_zero: assert property (@(posedge clk_sys) disable iff (rst)
      restart |=> ref_now == 14'h0000)
      else $error("reference not held at zero");
   a_slew_bound: assert property (@(posedge clk_sys) disable iff (rst)
      !restart |=> (ref_now - $past(ref_now) <= brs_pkg::REF_STEP) ||
                   ($past(ref_now) - ref_now <= brs_pkg::REF_STEP))
      else $error("reference stepped too far");
   a_slew_idle: assert property (@(posedge clk_sys) disable iff (rst)
      (!restart && !step) |=> $stable(ref_now))
      else $error("reference moved between slew ticks");
endmodule

// *** hw/brs_top.sv ***
// regulator sequencer: enable, soft start, switch drive, faults, registers
// Functional notes
// - reference is 0.6 V plus code times 4.7 mV
// - feedback below reference: high side on, else low
// - light-load mode skips low side at zero current
// - host sets enable, mode, slew, overvoltage protection
// - output-ok watches under and over, or under only
// - active only with enable pin and supply good
// - after bias settles, reference ramps from zero
// - output-ok low in ramp, then 45 ms delay
// - ramp always runs in light-load mode
// - peak current trip blanks high side 360 ns
// - feedback low: both off 1.2 ms, restart ramp
// - no feedback-low detection during startup
// - feedback-low trip is 80 percent of reference
`timescale 1ns/10ps
module brs_top #(
   parameter int         PG_DELAY_CYC = brs_pkg::PG_DELAY_CYC,
   parameter int         HICCUP_CYC   = brs_pkg::HICCUP_CYC,
   parameter logic [6:0] REF_CODE_RST = brs_pkg::REF_CODE_RST
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // pins and comparators
   input  wire logic        enable_pin,
   input  wire logic        power_input_supply_ok,
   input  wire logic        peak_current_limit,
   input  wire logic        zero_current,
   input  wire logic        vin_overvoltage,
   // on-chip feedback converter, 0.1 mV units
   input  wire logic [13:0] feedback_input,
   // power stage and flags
   output logic             hs_on,
   output logic             ls_on,
   output logic             output_ok_flag,
   output logic             irq
);
   typedef struct packed {
      brs_pkg::brs_state_t st;
      logic [5:0]          ctrl;
      logic [6:0]          ref_code;
      logic [4:0]          irq_stat;
      logic [4:0]          irq_en;
      logic                wreq;
      logic [31:0]         rdata;
      logic [23:0]         timer;
      logic [23:0]         pg_cnt;
      logic [6:0]          blank;
      logic                oc_prev;
      logic                hs;
      logic                ls;
      logic                ok;
      logic                irq;
   } brs_top_t;

   brs_top_t    r;
   brs_top_t    next_r;
   logic [4:0]  pins;
   logic        en_s;
   logic        sup_s;
   logic        oc_s;
   logic        zc_s;
   logic        ovp_s;
   logic [13:0] target;
   logic [13:0] ref_now;
   logic        at_target;
   logic        restart;
   logic        live;
   logic        active;
   logic        light;
   logic        below;
   logic        uv_trip;
   logic        pg_ok;
   logic        oc_rise;
   logic        wr_ok;
   logic [17:0] fb10;
   logic [17:0] ref18;
   logic [4:0]  ev;
   logic [4:0]  clr;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and reference stepper
   brs_sync #(
      .W (5)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     ({enable_pin, power_input_supply_ok, peak_current_limit,
                 zero_current, vin_overvoltage}),
      .dout    (pins)
   );

   assign {en_s, sup_s, oc_s, zc_s, ovp_s} = pins;

   assign target  = brs_pkg::REF_BASE +
                    14'(r.ref_code) * brs_pkg::REF_STEP;
   assign restart = (r.st == brs_pkg::ST_OFF) ||
                    (r.st == brs_pkg::ST_BIAS) ||
                    (r.st == brs_pkg::ST_HICCUP);

   brs_ref_slew u_slew (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .restart   (restart),
      .slew_sel  (r.ctrl[brs_pkg::CTRL_SLEW +: 2]),
      .target    (target),
      .ref_now   (ref_now),
      .at_target (at_target)
   );

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_r  = r;
      ev      = '0;
      clr     = '0;
      fb10    = 18'(feedback_input) * brs_pkg::TENTHS;
      ref18   = 18'(ref_now);
      live    = en_s && sup_s && r.ctrl[brs_pkg::CTRL_EN] &&
                !(r.ctrl[brs_pkg::CTRL_OVP] && ovp_s);
      active  = (r.st == brs_pkg::ST_RAMP) || (r.st == brs_pkg::ST_RUN);
      light   = r.ctrl[brs_pkg::CTRL_PSM] ||
                (r.st == brs_pkg::ST_RAMP);
      below   = feedback_input < ref_now;
      uv_trip = fb10 < ref18 * brs_pkg::TRIP_TEN;
      pg_ok   = (fb10 >= ref18 * brs_pkg::OK_LO_TEN) &&
                (r.ctrl[brs_pkg::CTRL_UVONLY] ||
                 fb10 <= ref18 * brs_pkg::OK_HI_TEN);
      oc_rise = oc_s && !r.oc_prev;
      wr_ok   = avs_write && !r.wreq;
      next_r.oc_prev = oc_s;

      // peak current blanking
      if (active && oc_rise) begin
         next_r.blank = 7'(brs_pkg::BLANK_CYC);
         ev[brs_pkg::EV_OCP] = 1'b1;
      end else if (r.blank != '0) begin
         next_r.blank = r.blank - 7'h01;
      end

      // sequencer
      unique case (r.st)
         brs_pkg::ST_OFF: begin
            next_r.timer = '0;
            if (live) begin
               next_r.st = brs_pkg::ST_BIAS;
            end
         end
         brs_pkg::ST_BIAS: begin
            next_r.timer = r.timer + 24'h000001;
            if (r.timer == 24'(brs_pkg::BIAS_CYC - 1)) begin
               next_r.st = brs_pkg::ST_RAMP;
            end
         end
         brs_pkg::ST_RAMP: begin
            next_r.timer = '0;
            if (at_target) begin
               next_r.st = brs_pkg::ST_RUN;
            end
         end
         brs_pkg::ST_RUN: begin
            if (uv_trip) begin
               next_r.st    = brs_pkg::ST_HICCUP;
               next_r.timer = '0;
               ev[brs_pkg::EV_HICCUP] = 1'b1;
            end
         end
         brs_pkg::ST_HICCUP: begin
            next_r.timer = r.timer + 24'h000001;
            if (r.timer == 24'(HICCUP_CYC - 1)) begin
               next_r.st = brs_pkg::ST_RAMP;
            end
         end
         default: begin
            next_r.st = brs_pkg::ST_OFF;
         end
      endcase
      if (!live) begin
         next_r.st = brs_pkg::ST_OFF;
      end
      if (active && r.ctrl[brs_pkg::CTRL_OVP] && ovp_s) begin
         ev[brs_pkg::EV_OVP] = 1'b1;
      end

      // switch drive
      next_r.hs = 1'b0;
      next_r.ls = 1'b0;
      if (active && live && !(r.st == brs_pkg::ST_RUN && uv_trip)) begin
         if (below) begin
            next_r.hs = (r.blank == '0) && !oc_rise;
         end else begin
            next_r.ls = !(light && zc_s);
         end
      end

      // output-ok with delay
      if (live && r.st == brs_pkg::ST_RUN && !uv_trip && pg_ok) begin
         if (r.pg_cnt == 24'(PG_DELAY_CYC - 1)) begin
            next_r.ok = 1'b1;
         end else begin
            next_r.pg_cnt = r.pg_cnt + 24'h000001;
         end
      end else begin
         next_r.pg_cnt = '0;
         next_r.ok     = 1'b0;
      end
      ev[brs_pkg::EV_OK_RISE] = next_r.ok && !r.ok;
      ev[brs_pkg::EV_OK_FALL] = !next_r.ok && r.ok;

      // register writes
      if (wr_ok) begin
         unique case (avs_address)
            brs_pkg::OFS_CTRL:
               next_r.ctrl = avs_writedata[5:0];
            brs_pkg::OFS_REF:
               next_r.ref_code = avs_writedata[6:0];
            brs_pkg::OFS_IRQ_CLR:
               clr = avs_writedata[4:0];
            brs_pkg::OFS_IRQ_EN:
               next_r.irq_en = avs_writedata[4:0];
            default: begin
            end
         endcase
      end
      next_r.irq_stat = (r.irq_stat & ~clr) | ev;
      next_r.irq      = |(next_r.irq_stat & next_r.irq_en);

      // bus answer one cycle after the request
      if ((avs_read || avs_write) && r.wreq) begin
         next_r.wreq  = 1'b0;
         next_r.rdata = '0;
         unique case (avs_address)
            brs_pkg::OFS_CTRL:     next_r.rdata[5:0] = r.ctrl;
            brs_pkg::OFS_REF:      next_r.rdata[6:0] = r.ref_code;
            brs_pkg::OFS_STATUS: begin
               next_r.rdata[13:0] = ref_now;
               next_r.rdata[brs_pkg::STAT_ST +: 3] = r.st;
               next_r.rdata[brs_pkg::STAT_OK] = r.ok;
            end
            brs_pkg::OFS_IRQ_STAT: next_r.rdata[4:0] = r.irq_stat;
            brs_pkg::OFS_IRQ_EN:   next_r.rdata[4:0] = r.irq_en;
            default:               next_r.rdata = '0;
         endcase
      end else begin
         next_r.wreq = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r          <= '0;
         r.st       <= brs_pkg::ST_OFF;
         r.ctrl     <= brs_pkg::CTRL_RST;
         r.ref_code <= REF_CODE_RST;
         r.wreq     <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = r.wreq;
   assign hs_on           = r.hs;
   assign ls_on           = r.ls;
   assign output_ok_flag  = r.ok;
   assign irq             = r.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_hic_trip;
      r.st == brs_pkg::ST_RUN && uv_trip && live;
   endsequence
   sequence s_hic_done;
      r.st == brs_pkg::ST_HICCUP && live &&
      r.timer == 24'(HICCUP_CYC - 1);
   endsequence

   a_hs_below: assert property (
      (r.st == brs_pkg::ST_RUN && live && !uv_trip && below &&
       r.blank == '0 && !oc_rise) |=> hs_on && !ls_on)
      else $error("high side not on below reference");
   a_ls_above: assert property (
      (r.st == brs_pkg::ST_RUN && live && !below && !light)
      |=> ls_on && !hs_on)
      else $error("low side not on above reference");
   a_psm_skip: assert property (
      (r.st == brs_pkg::ST_RUN && r.ctrl[brs_pkg::CTRL_PSM] && zc_s)
      |=> !ls_on)
      else $error("low side on at zero current in light load");
   a_ramp_light: assert property (
      (r.st == brs_pkg::ST_RAMP && zc_s) |=> !ls_on)
      else $error("ramp not in light-load mode");
   a_blank_load: assert property (
      (active && oc_rise) |=> r.blank == 7'(brs_pkg::BLANK_CYC) && !hs_on)
      else $error("current trip did not blank high side");
   a_blank_hold: assert property (
      (r.blank != '0) |=> !hs_on)
      else $error("high side on during blanking");
   a_pg_ramp: assert property (
      (r.st == brs_pkg::ST_RAMP) |=> !output_ok_flag)
      else $error("output ok high during ramp");
   a_pg_delay: assert property (
      $rose(output_ok_flag) |-> $past(r.pg_cnt) == 24'(PG_DELAY_CYC - 1))
      else $error("output ok rose without full delay");
   a_hic_enter: assert property (
      s_hic_trip |=> r.st == brs_pkg::ST_HICCUP ##1 !hs_on && !ls_on)
      else $error("feedback low did not start hiccup");
   a_hic_exit: assert property (
      s_hic_done |=> r.st == brs_pkg::ST_RAMP && ref_now == 14'h0000)
      else $error("hiccup did not restart soft start");
   a_no_uv_ramp: assert property (
      (r.st == brs_pkg::ST_RAMP) |=> r.st != brs_pkg::ST_HICCUP)
      else $error("hiccup during startup");
   a_enable_gate: assert property (
      !live |=> r.st == brs_pkg::ST_OFF ##1 !hs_on && !ls_on)
      else $error("regulator active without enable");
   a_ctrl_write: assert property (
      (wr_ok && avs_address == brs_pkg::OFS_CTRL)
      |=> r.ctrl == $past(avs_writedata[5:0]))
      else $error("control write lost");
endmodule

// *** bench/brs_plant.sv ***
// behavioural power stage turning switch drive into a feedback level
`timescale 1ns/10ps
module brs_plant (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // switch drive and bench override
   input  wire logic        hs_on,
   input  wire logic        ls_on,
   input  wire logic        force_en,
   input  wire logic [13:0] force_val,
   // feedback level
   output logic      [13:0] feedback_input
);
   typedef struct packed {
      logic [13:0] fb;
   } brs_plant_st_t;
   brs_plant_st_t st;
   brs_plant_st_t next_st;
   ///////////////////////////////////////////////////////////////////////////
   // inductor charges on high side, discharges on low side
   always_comb begin
      next_st = st;
      if (force_en) begin
         next_st.fb = force_val;
      end else if (hs_on && st.fb < 14'h3ff0) begin
         next_st.fb = st.fb + 14'h0008;
      end else if (ls_on && st.fb > 14'h0008) begin
         next_st.fb = st.fb - 14'h0008;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign feedback_input = st.fb;
endmodule

// *** bench/brs_top_bench.sv ***
// self-checking bench for the regulator sequencer
`timescale 1ns/10ps
module brs_top_bench;
   localparam int PG  = 50;
   localparam int HIC = 40;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        enable_pin = 1'b0;
   logic        power_input_supply_ok = 1'b0;
   logic        peak_current_limit = 1'b0;
   logic        zero_current = 1'b0;
   logic        vin_overvoltage = 1'b0;
   logic        force_en = 1'b1;
   logic [13:0] force_val = 14'h0;
   logic [13:0] feedback_input;
   logic        hs_on;
   logic        ls_on;
   logic        output_ok_flag;
   logic        irq;
   int          mismatches = 0;
   int          tests_run = 0;
   int          n;
   int          off;
   logic [31:0] q;
   logic [6:0]  code;
   logic [13:0] tgt;
   logic        up;
   always #2.5 clk_sys = ~clk_sys;
   brs_top #(.PG_DELAY_CYC(PG), .HICCUP_CYC(HIC)) dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .enable_pin(enable_pin),
      .power_input_supply_ok(power_input_supply_ok),
      .peak_current_limit(peak_current_limit), .zero_current(zero_current),
      .vin_overvoltage(vin_overvoltage), .feedback_input(feedback_input),
      .hs_on(hs_on), .ls_on(ls_on), .output_ok_flag(output_ok_flag),
      .irq(irq));
   brs_plant plant (
      .clk_sys(clk_sys), .rst(rst), .hs_on(hs_on), .ls_on(ls_on),
      .force_en(force_en), .force_val(force_val),
      .feedback_input(feedback_input));
   ///////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [13:0] lvl(input logic [6:0] c);
      return 14'h1770 + 14'h002f * {7'h00, c};
   endfunction
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (k >= 100) begin
         mismatches++;
         end_sim();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_st(input logic [2:0] st);
      int k;
      k = 0;
      do begin
         rd(brs_pkg::OFS_STATUS);
         if (q[18:16] === brs_pkg::ST_RAMP) chk(q[20], 1'b0);
         k++;
      end while (q[18:16] !== st && k < 15000);
      chk(q[18:16], st);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
   endtask
   ///////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      n = $urandom(7447);
      cyc(6);
      rst <= 1'b0;
      rd(brs_pkg::OFS_CTRL);
      chk(q, 32'h3);
      rd(brs_pkg::OFS_REF);
      chk(q, 32'h40);
      rd(8'h20);
      chk(q, 32'h0);
      code = 7'($urandom % 32);
      tgt  = lvl(code);
      bus(1'b1, brs_pkg::OFS_CTRL, 32'h1);
      bus(1'b1, brs_pkg::OFS_REF, {25'h0, code});
      rd(brs_pkg::OFS_REF);
      chk(q, {25'h0, code});
      // pin high but supply low stays off
      enable_pin <= 1'b1;
      cyc(10);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], 3'h0);
      chk({hs_on, ls_on}, 2'b00);
      power_input_supply_ok <= 1'b1;
      wait_st(brs_pkg::ST_RAMP);
      chk(q[13:0] < 14'h0080, 1'b1);
      // light-load forced in ramp, no low trip while ramping
      force_val    <= tgt + 14'h0200;
      zero_current <= 1'b1;
      cyc(6);
      chk({hs_on, ls_on}, 2'b00);
      force_val <= 14'h0;
      cyc(220);
      chk({hs_on, ls_on}, 2'b10);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], brs_pkg::ST_RAMP);
      force_en     <= 1'b0;
      zero_current <= 1'b0;
      wait_st(brs_pkg::ST_RUN);
      chk(q[13:0], tgt);
      // random feedback around the reference, fixed mode
      force_en <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         off = $urandom % 400 + 1;
         up  = 1'($urandom % 2);
         force_val <= up ? tgt + 14'(off) : tgt - 14'(off);
         cyc(5);
         chk({hs_on, ls_on}, up ? 2'b01 : 2'b10);
      end
      force_val    <= tgt + 14'h0064;
      zero_current <= 1'b1;
      cyc(5);
      chk({hs_on, ls_on}, 2'b01);
      bus(1'b1, brs_pkg::OFS_CTRL, 32'h3);
      cyc(4);
      chk({hs_on, ls_on}, 2'b00);
      zero_current <= 1'b0;
      // output-ok delay, then over-limit handling
      force_val <= 14'((int'(tgt) * 85) / 100);
      cyc(6);
      chk(output_ok_flag, 1'b0);
      force_val <= tgt;
      n = 0;
      while (output_ok_flag !== 1'b1 && n < PG + 20) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n >= PG && n <= PG + 6, 1'b1);
      force_val <= tgt + tgt / 5;
      cyc(6);
      chk(output_ok_flag, 1'b0);
      bus(1'b1, brs_pkg::OFS_CTRL, 32'hb);
      cyc(PG + 12);
      chk(output_ok_flag, 1'b1);
      // peak current blanking and its interrupt
      force_val <= tgt - 14'h0064;
      cyc(6);
      chk(hs_on, 1'b1);
      peak_current_limit <= 1'b1;
      n = 0;
      while (hs_on !== 1'b0 && n < 10) begin
         @(posedge clk_sys);
         n++;
      end
      peak_current_limit <= 1'b0;
      n = 0;
      while (hs_on !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n >= brs_pkg::BLANK_CYC - 1 &&
          n <= brs_pkg::BLANK_CYC + 4, 1'b1);
      rd(brs_pkg::OFS_IRQ_STAT);
      chk(q[0], 1'b1);
      chk(irq, 1'b0);
      bus(1'b1, brs_pkg::OFS_IRQ_EN, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      bus(1'b1, brs_pkg::OFS_IRQ_CLR, 32'h1f);
      cyc(2);
      chk(irq, 1'b0);
      rd(brs_pkg::OFS_IRQ_CLR);
      chk(q, 32'h0);
      // on-the-fly code change slews
      force_en <= 1'b0;
      bus(1'b1, brs_pkg::OFS_CTRL, 32'h1b);
      bus(1'b1, brs_pkg::OFS_REF, {25'h0, code + 7'h03});
      rd(brs_pkg::OFS_STATUS);
      chk(q[13:0] < lvl(code + 7'h03), 1'b1);
      tgt = lvl(code + 7'h03);
      n = 0;
      while (q[13:0] !== tgt && n < 1000) begin
         rd(brs_pkg::OFS_STATUS);
         n++;
      end
      chk(q[13:0], tgt);
      chk(n * 3 >= 800, 1'b1);
      // feedback-low trip edge and hiccup restart
      force_en  <= 1'b1;
      force_val <= 14'((int'(tgt) * 8 + 9) / 10);
      cyc(20);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], brs_pkg::ST_RUN);
      force_val <= 14'((int'(tgt) * 8 + 9) / 10) - 14'h0001;
      cyc(4);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], brs_pkg::ST_HICCUP);
      for (int i = 0; i < HIC - 12; i++) begin
         @(posedge clk_sys);
         chk({hs_on, ls_on}, 2'b00);
      end
      wait_st(brs_pkg::ST_RAMP);
      chk(q[13:0] < tgt, 1'b1);
      rd(brs_pkg::OFS_IRQ_STAT);
      chk(q[1], 1'b1);
      // input overvoltage only shuts down once protection is on
      vin_overvoltage <= 1'b1;
      cyc(6);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], brs_pkg::ST_RAMP);
      bus(1'b1, brs_pkg::OFS_CTRL, 32'h5);
      cyc(4);
      rd(brs_pkg::OFS_STATUS);
      chk(q[18:16], brs_pkg::ST_OFF);
      chk({hs_on, ls_on}, 2'b00);
      rd(brs_pkg::OFS_IRQ_STAT);
      chk(q[4], 1'b1);
      end_sim();
   end
   initial begin
      cyc(80000);
      mismatches++;
      end_sim();
   end
endmodule
